// *** rdpa_defines.svh ***
// Constants for the dynamic payload and acknowledge control block
`ifndef RDPA_DEFINES_SVH
`define RDPA_DEFINES_SVH

`define RDPA_ADDR_VARLEN      8'h1C
`define RDPA_ADDR_FEATURE     8'h1D
`define RDPA_ADDR_RTD         8'h04
`define RDPA_ADDR_STATUS      8'h07
`define RDPA_ADDR_FIFO_STATUS 8'h17

`define RDPA_VARLEN_MASK      8'h3F
`define RDPA_FEATURE_MASK     8'h07
`define RDPA_VARLEN_RESET     8'h00
`define RDPA_FEATURE_RESET    8'h00
`define RDPA_RTD_RESET        4'h0

`define RDPA_FEAT_DPL_BIT     2
`define RDPA_FEAT_ACKPAY_BIT  1
`define RDPA_FEAT_NOACK_BIT   0
`define RDPA_STAT_RXDR_BIT    6
`define RDPA_FS_ACK_FULL_BIT  5
`define RDPA_FS_RX_FULL_BIT   1
`define RDPA_FS_RX_EMPTY_BIT  0

`define RDPA_CLK_MHZ          10
`define RDPA_LISTEN_US        250
`define RDPA_LISTEN_CYC       (`RDPA_LISTEN_US * `RDPA_CLK_MHZ)
`define RDPA_RTD_STEP_US      250
`define RDPA_RTD_STEP_CYC     (`RDPA_RTD_STEP_US * `RDPA_CLK_MHZ)
`define RDPA_RTD_MIN_US       500
`define RDPA_ACK_LEN_2M       15
`define RDPA_ACK_LEN_1M       5

`define RDPA_H_CMD            8'h00
`define RDPA_H_RESULT         8'h04
`define RDPA_H_IRQ_STATUS     8'h08
`define RDPA_H_IRQ_MASK       8'h0C
`define RDPA_H_CFG            8'h10
`define RDPA_H_PAYLOAD        8'h20
`define RDPA_RATE_1M          2'h0
`define RDPA_RATE_2M          2'h1
`define RDPA_RATE_250K        2'h2

`endif

// *** rdpa_pkg.sv ***
// Types shared by both ends of the payload and acknowledge link
package rdpa_pkg;
	typedef enum logic [1:0]
	{
		RDPA_OP_RD_REG     = 2'h0,
		RDPA_OP_WR_REG     = 2'h1,
		RDPA_OP_RD_PAYLOAD = 2'h2,
		RDPA_OP_WR_ACK     = 2'h3
	} rdpa_op_type;

	typedef enum logic [3:0]
	{
		RDPA_ST_IDLE    = 4'h1,
		RDPA_ST_TX      = 4'h2,
		RDPA_ST_LISTEN  = 4'h4,
		RDPA_ST_STANDBY = 4'h8
	} rdpa_state_type;
endpackage

// *** rdpa_if.sv ***
// Command link between the controller and the transceiver registers
`timescale 1ns/1ps
interface rdpa_if;
	import rdpa_pkg::*;
	logic          req;
	rdpa_op_type   op;
	logic [7:0]    addr;
	logic [7:0]    wdata;
	logic [2:0]    pipe;
	logic [5:0]    len;
	logic [255:0]  payload;
	logic          rsp_valid;
	logic [7:0]    rsp_byte;
	logic [5:0]    rsp_len;
	logic [2:0]    rsp_pipe;
	logic [255:0]  rsp_payload;
	logic          irq;

	modport dev
	(
		input  req, op, addr, wdata, pipe, len, payload,
		output rsp_valid, rsp_byte, rsp_len, rsp_pipe, rsp_payload, irq
	);
	modport host
	(
		output req, op, addr, wdata, pipe, len, payload,
		input  rsp_valid, rsp_byte, rsp_len, rsp_pipe, rsp_payload, irq
	);
endinterface

// *** rdpa_fifo.sv ***
// Small first-in first-out queue with registered full and empty flags
`timescale 1ns/1ps
module rdpa_fifo #(
	parameter int WIDTH = 265,
	parameter int DEPTH = 3
)
(
	input  wire logic             clk_i,
	input  wire logic             arst_n_i,
	input  wire logic             push_i,
	input  wire logic [WIDTH-1:0] data_i,
	input  wire logic             pop_i,
	output logic      [WIDTH-1:0] data_o,
	output logic                  full_o,
	output logic                  empty_o
);
	localparam int PW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    rd_ptr;
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    count;
	logic             do_push;
	logic             do_pop;

	assign do_push = push_i && !full_o;
	assign do_pop  = pop_i && !empty_o;
	assign data_o  = mem[rd_ptr];

	function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
		wrap_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	always_ff @(posedge clk_i)
	begin
		if (do_push)
			mem[wr_ptr] <= data_i;
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rd_ptr  <= '0;
			wr_ptr  <= '0;
			count   <= '0;
			full_o  <= 1'b0;
			empty_o <= 1'b1;
		end
		else
		begin
			if (do_push)
				wr_ptr <= wrap_inc(wr_ptr);
			if (do_pop)
				rd_ptr <= wrap_inc(rd_ptr);
			if (do_push && !do_pop)
			begin
				count   <= count + PW'(1);
				full_o  <= (count == PW'(DEPTH - 1));
				empty_o <= 1'b0;
			end
			else if (do_pop && !do_push)
			begin
				count   <= count - PW'(1);
				full_o  <= 1'b0;
				empty_o <= (count == PW'(1));
			end
		end
	end
endmodule

// *** rdpa_device.sv ***
// Transceiver end: receive queue, acknowledge queue, feature registers, retransmit timing
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "rdpa_defines.svh"
module rdpa_device
	import rdpa_pkg::*;
#(
	parameter int DEPTH      = 3,
	parameter int LISTEN_CYC = `RDPA_LISTEN_CYC,
	parameter int STEP_CYC   = `RDPA_RTD_STEP_CYC
)
(
	input  wire logic         clk_i,
	input  wire logic         arst_n_i,
	rdpa_if.dev               link,
	input  wire logic         rx_valid_i,
	input  wire logic [2:0]   rx_pipe_i,
	input  wire logic [5:0]   rx_len_i,
	input  wire logic [255:0] rx_data_i,
	output logic              rx_ready_o,
	input  wire logic [5:0]   auto_ack_i,
	output logic      [5:0]   varlen_active_o,
	output logic              ack_varlen_o,
	output logic              no_ack_command_enable_o,
	output logic              ack_valid_o,
	output logic      [2:0]   ack_pipe_o,
	output logic      [5:0]   ack_len_o,
	output logic      [255:0] ack_data_o,
	input  wire logic         ack_take_i,
	input  wire logic         tx_request_i,
	input  wire logic         tx_done_i,
	input  wire logic         rx_active_i,
	input  wire logic         ack_ok_i,
	output logic              tx_enable_o,
	output logic              rx_enable_o,
	output logic              standby_o
);
	localparam int EW = 265;

	logic [7:0]     dynamic_length_pipe_enable;
	logic [7:0]     radio_feature_control;
	logic [3:0]     auto_retransmit_delay;
	logic           receive_data_ready_flag;
	rdpa_state_type state;
	logic [15:0]    listen_cnt;
	logic [15:0]    delay_cnt;
	logic [15:0]    delay_cyc;
	logic [EW-1:0]  rx_head;
	logic           rx_full;
	logic           rx_empty;
	logic           rx_push;
	logic           rx_pop;
	logic [EW-1:0]  ack_head;
	logic           ack_full;
	logic           ack_empty;
	logic           ack_push;
	logic           ack_pop;
	logic           wr_reg;

	assign wr_reg   = link.req && (link.op == RDPA_OP_WR_REG);
	assign rx_push  = rx_valid_i && !rx_full;
	assign rx_pop   = link.req && (link.op == RDPA_OP_RD_PAYLOAD);
	assign ack_push = link.req && (link.op == RDPA_OP_WR_ACK);
	assign ack_pop  = ack_take_i && !ack_empty;
	assign delay_cyc = 16'((32'(auto_retransmit_delay) + 32'd1) * STEP_CYC);

	function automatic logic [7:0] reg_read(input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			`RDPA_ADDR_VARLEN:
				v = dynamic_length_pipe_enable & `RDPA_VARLEN_MASK;
			`RDPA_ADDR_FEATURE:
				v = radio_feature_control & `RDPA_FEATURE_MASK;
			`RDPA_ADDR_RTD:
				v = {4'h0, auto_retransmit_delay};
			`RDPA_ADDR_STATUS:
			begin
				v[`RDPA_STAT_RXDR_BIT] = receive_data_ready_flag;
				v[3:1] = rx_empty ? 3'h7 : rx_head[264:262];
			end
			`RDPA_ADDR_FIFO_STATUS:
			begin
				v[`RDPA_FS_ACK_FULL_BIT] = ack_full;
				v[`RDPA_FS_RX_FULL_BIT]  = rx_full;
				v[`RDPA_FS_RX_EMPTY_BIT] = rx_empty;
			end
			default:
				v = 8'h00;
		endcase
		return v;
	endfunction

	rdpa_fifo #(
		.WIDTH (EW),
		.DEPTH (DEPTH)
	) u_rx_fifo (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.push_i   (rx_push),
		.data_i   ({rx_pipe_i, rx_len_i, rx_data_i}),
		.pop_i    (rx_pop),
		.data_o   (rx_head),
		.full_o   (rx_full),
		.empty_o  (rx_empty)
	);

	rdpa_fifo #(
		.WIDTH (EW),
		.DEPTH (DEPTH)
	) u_ack_fifo (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.push_i   (ack_push),
		.data_i   ({link.pipe, link.len, link.payload}),
		.pop_i    (ack_pop),
		.data_o   (ack_head),
		.full_o   (ack_full),
		.empty_o  (ack_empty)
	);

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			dynamic_length_pipe_enable <= `RDPA_VARLEN_RESET;
		else if (wr_reg && (link.addr == `RDPA_ADDR_VARLEN))
			dynamic_length_pipe_enable <= link.wdata & `RDPA_VARLEN_MASK;
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			radio_feature_control <= `RDPA_FEATURE_RESET;
		else if (wr_reg && (link.addr == `RDPA_ADDR_FEATURE))
			radio_feature_control <= link.wdata & `RDPA_FEATURE_MASK;
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			auto_retransmit_delay <= `RDPA_RTD_RESET;
		else if (wr_reg && (link.addr == `RDPA_ADDR_RTD))
			auto_retransmit_delay <= link.wdata[3:0];
	end

	// arrival sets flag, set beats clear
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			receive_data_ready_flag <= 1'b0;
		else if (rx_push)
			receive_data_ready_flag <= 1'b1;
		else if (wr_reg && (link.addr == `RDPA_ADDR_STATUS) && link.wdata[`RDPA_STAT_RXDR_BIT])
			receive_data_ready_flag <= 1'b0;
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			link.rsp_valid   <= 1'b0;
			link.rsp_byte    <= 8'h00;
			link.rsp_len     <= 6'h00;
			link.rsp_pipe    <= 3'h0;
			link.rsp_payload <= '0;
		end
		else
		begin
			link.rsp_valid <= link.req;
			if (link.req)
			begin
				link.rsp_byte    <= (link.op == RDPA_OP_RD_REG) ? reg_read(link.addr) : 8'h00;
				link.rsp_len     <= 6'h00;
				link.rsp_pipe    <= 3'h7;
				link.rsp_payload <= '0;
				if (link.op == RDPA_OP_RD_PAYLOAD && !rx_empty)
				begin
					link.rsp_pipe    <= rx_head[264:262];
					link.rsp_len     <= rx_head[261:256];
					link.rsp_payload <= rx_head[255:0];
				end
				if (link.op == RDPA_OP_WR_ACK)
					link.rsp_byte <= {7'h00, ack_full};
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			link.irq                <= 1'b0;
			rx_ready_o              <= 1'b0;
			varlen_active_o         <= 6'h00;
			ack_varlen_o            <= 1'b0;
			no_ack_command_enable_o <= 1'b0;
		end
		else
		begin
			link.irq   <= receive_data_ready_flag;
			rx_ready_o <= !rx_full && !(rx_push && !rx_pop);
			varlen_active_o <= dynamic_length_pipe_enable[5:0] & auto_ack_i
				& {6{radio_feature_control[`RDPA_FEAT_DPL_BIT]}};
			ack_varlen_o <= radio_feature_control[`RDPA_FEAT_ACKPAY_BIT];
			no_ack_command_enable_o <= radio_feature_control[`RDPA_FEAT_NOACK_BIT];
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ack_valid_o <= 1'b0;
			ack_pipe_o  <= 3'h0;
			ack_len_o   <= 6'h00;
			ack_data_o  <= '0;
		end
		else
		begin
			ack_valid_o <= !ack_empty && !ack_pop;
			ack_pipe_o  <= ack_head[264:262];
			ack_len_o   <= ack_head[261:256];
			ack_data_o  <= ack_head[255:0];
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state      <= RDPA_ST_IDLE;
			listen_cnt <= 16'h0000;
			delay_cnt  <= 16'h0000;
		end
		else
		begin
			unique case (state)
				RDPA_ST_IDLE:
					if (tx_request_i)
						state <= RDPA_ST_TX;
				RDPA_ST_TX:
				begin
					listen_cnt <= 16'h0000;
					delay_cnt  <= 16'h0000;
					if (tx_done_i)
						state <= RDPA_ST_LISTEN;
				end
				RDPA_ST_LISTEN:
				begin
					listen_cnt <= listen_cnt + 16'h0001;
					delay_cnt  <= delay_cnt + 16'h0001;
					if (ack_ok_i)
						state <= RDPA_ST_IDLE;
					else if (listen_cnt >= 16'(LISTEN_CYC - 1) && !rx_active_i)
						state <= (delay_cnt >= delay_cyc - 16'h0001) ? RDPA_ST_TX
							: RDPA_ST_STANDBY;
				end
				RDPA_ST_STANDBY:
				begin
					delay_cnt <= delay_cnt + 16'h0001;
					if (delay_cnt >= delay_cyc - 16'h0001)
						state <= RDPA_ST_TX;
				end
			endcase
		end
	end

	assign tx_enable_o = state[1];
	assign rx_enable_o = state[2];
	assign standby_o   = state[3];
endmodule

// *** rdpa_host.sv ***
// Controller end: software registers that issue commands over the link
`timescale 1ns/1ps
`include "rdpa_defines.svh"
module rdpa_host
	import rdpa_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	rdpa_if.host             link,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	output logic             irq_o
);
	logic [31:0] payload_mem [8];
	logic [7:0]  result_byte;
	logic [5:0]  result_len;
	logic [2:0]  result_pipe;
	logic        busy;
	logic [1:0]  irq_status;
	logic [1:0]  irq_mask;
	logic        irq_seen;
	logic [1:0]  air_rate;
	logic [7:0]  shadow_varlen;
	logic [7:0]  shadow_feature;
	logic [3:0]  shadow_rtd;
	logic [5:0]  max_ack_len;
	logic [1:0]  warn;
	logic        cmd_wr;
	logic        irq_rise;
	logic [7:0]  cmd_data;

	assign cmd_wr   = wr_i && (addr_i == `RDPA_H_CMD) && !busy;
	assign irq_rise = link.irq && !irq_seen;
	assign cmd_data = (wdata_i[23:16] == `RDPA_ADDR_VARLEN) ? wdata_i[31:24] & `RDPA_VARLEN_MASK
		: (wdata_i[23:16] == `RDPA_ADDR_FEATURE) ? wdata_i[31:24] & `RDPA_FEATURE_MASK
		: wdata_i[31:24];

	generate
		for (genvar i = 0; i < 8; i++)
		begin : g_pay
			assign link.payload[32*i +: 32] = payload_mem[i];
		end
	endgenerate

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			link.req   <= 1'b0;
			link.op    <= RDPA_OP_RD_REG;
			link.addr  <= 8'h00;
			link.wdata <= 8'h00;
			link.pipe  <= 3'h0;
			link.len   <= 6'h00;
			busy       <= 1'b0;
		end
		else
		begin
			link.req <= cmd_wr;
			if (cmd_wr)
			begin
				link.op    <= rdpa_op_type'(wdata_i[1:0]);
				link.pipe  <= wdata_i[4:2];
				link.len   <= wdata_i[10:5];
				link.addr  <= wdata_i[23:16];
				link.wdata <= cmd_data;
				busy       <= 1'b1;
			end
			else if (link.rsp_valid)
				busy <= 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (wr_i && addr_i[7:5] == 3'h1 && addr_i[1:0] == 2'h0)
			payload_mem[addr_i[4:2]] <= wdata_i;
		else if (link.rsp_valid && link.op == RDPA_OP_RD_PAYLOAD)
			for (int i = 0; i < 8; i++)
				payload_mem[i] <= link.rsp_payload[32*i +: 32];
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			result_byte <= 8'h00;
			result_len  <= 6'h00;
			result_pipe <= 3'h0;
		end
		else if (link.rsp_valid)
		begin
			result_byte <= link.rsp_byte;
			result_len  <= link.rsp_len;
			result_pipe <= link.rsp_pipe;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			shadow_varlen  <= 8'h00;
			shadow_feature <= 8'h00;
			shadow_rtd     <= 4'h0;
			max_ack_len    <= 6'h00;
			air_rate       <= `RDPA_RATE_1M;
		end
		else
		begin
			if (wr_i && addr_i == `RDPA_H_CFG)
				air_rate <= wdata_i[1:0];
			if (cmd_wr && wdata_i[1:0] == 2'h1 && wdata_i[23:16] == `RDPA_ADDR_VARLEN)
				shadow_varlen <= cmd_data;
			if (cmd_wr && wdata_i[1:0] == 2'h1 && wdata_i[23:16] == `RDPA_ADDR_FEATURE)
				shadow_feature <= cmd_data;
			if (cmd_wr && wdata_i[1:0] == 2'h1 && wdata_i[23:16] == `RDPA_ADDR_RTD)
				shadow_rtd <= cmd_data[3:0];
			if (cmd_wr && wdata_i[1:0] == 2'h3 && wdata_i[10:5] > max_ack_len)
				max_ack_len <= wdata_i[10:5];
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			warn <= 2'h0;
		else
		begin
			// delay too short for rate and ack size
			warn[0] <= (32'(shadow_rtd) + 32'd1) * `RDPA_RTD_STEP_US < `RDPA_RTD_MIN_US
				&& ((air_rate == `RDPA_RATE_250K)
				|| (air_rate == `RDPA_RATE_2M && max_ack_len > 6'(`RDPA_ACK_LEN_2M))
				|| (air_rate == `RDPA_RATE_1M && max_ack_len > 6'(`RDPA_ACK_LEN_1M)));
			warn[1] <= shadow_feature[`RDPA_FEAT_ACKPAY_BIT] && !shadow_varlen[0];
		end
	end

	// receive-ready and command-response events latched for the read, clear, check loop
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			irq_seen   <= 1'b0;
			irq_status <= 2'h0;
			irq_mask   <= 2'h0;
			irq_o      <= 1'b0;
		end
		else
		begin
			irq_seen <= link.irq;
			for (int i = 0; i < 2; i++)
				if ((i == 0) ? irq_rise : link.rsp_valid)
					irq_status[i] <= 1'b1;
				else if (wr_i && addr_i == `RDPA_H_IRQ_STATUS && wdata_i[i])
					irq_status[i] <= 1'b0;
			if (wr_i && addr_i == `RDPA_H_IRQ_MASK)
				irq_mask <= wdata_i[1:0];
			irq_o <= |(irq_status & irq_mask);
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			rdata_o <= 32'h0000_0000;
		else if (rd_i)
		begin
			rdata_o <= 32'h0000_0000;
			if (addr_i == `RDPA_H_CMD)
				rdata_o <= {31'h0, busy};
			else if (addr_i == `RDPA_H_RESULT)
				rdata_o <= {13'h0, result_pipe, 2'h0, result_len, result_byte};
			else if (addr_i == `RDPA_H_IRQ_STATUS)
				rdata_o <= {30'h0, irq_status};
			else if (addr_i == `RDPA_H_IRQ_MASK)
				rdata_o <= {30'h0, irq_mask};
			else if (addr_i == `RDPA_H_CFG)
				rdata_o <= {28'h0, warn, air_rate};
			else if (addr_i[7:5] == 3'h1 && addr_i[1:0] == 2'h0)
				rdata_o <= payload_mem[addr_i[4:2]];
		end
	end
endmodule

// *** rdpa_chk.sv ***
// Assertions on the command link between controller and transceiver
`timescale 1ns/1ps
module rdpa_chk
	import rdpa_pkg::*;
(
	input  wire logic         clk_i,
	input  wire logic         arst_n_i,
	input  wire logic         req,
	input  rdpa_op_type       op,
	input  wire logic [7:0]   addr,
	input  wire logic [7:0]   wdata,
	input  wire logic         rsp_valid,
	input  wire logic [7:0]   rsp_byte,
	input  wire logic [5:0]   rsp_len,
	input  wire logic [2:0]   rsp_pipe,
	input  wire logic [255:0] rsp_payload
);
	logic [7:0] varlen_shadow;
	logic [7:0] feature_shadow;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);

	// Last value written to each enable register, reserved bits dropped
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			varlen_shadow  <= 8'h00;
			feature_shadow <= 8'h00;
		end
		else if (req && op == RDPA_OP_WR_REG && addr == 8'h1C)
			varlen_shadow  <= wdata & 8'h3F;
		else if (req && op == RDPA_OP_WR_REG && addr == 8'h1D)
			feature_shadow <= wdata & 8'h07;
	end

	AST_RSP_NEXT: assert property (req |=> rsp_valid)
		else $error("no response one cycle after request");
	AST_RSP_CAUSE: assert property (rsp_valid |-> $past(req))
		else $error("response without request");
	AST_REQ_SPACING: assert property (req |=> !req ##1 !req)
		else $error("request issued before previous answer");
	AST_VARLEN_READ: assert property (rsp_valid && $past(op) == RDPA_OP_RD_REG
		&& $past(addr) == 8'h1C |-> rsp_byte == varlen_shadow)
		else $error("variable length enables read back wrong");
	AST_FEATURE_READ: assert property (rsp_valid && $past(op) == RDPA_OP_RD_REG
		&& $past(addr) == 8'h1D |-> rsp_byte == feature_shadow)
		else $error("feature register read back wrong");
	AST_PAYLOAD_LEN: assert property (rsp_valid && $past(op) == RDPA_OP_RD_PAYLOAD
		|-> rsp_len <= 6'h20 && ((rsp_len == 6'h00) == (rsp_pipe == 3'h7)))
		else $error("payload length or empty marker wrong");
	AST_PAYLOAD_PIPE: assert property (rsp_valid && $past(op) == RDPA_OP_RD_PAYLOAD
		&& rsp_len != 6'h00 |-> rsp_pipe <= 3'h5)
		else $error("payload from a pipe that does not exist");
	AST_IDLE_RSP: assert property (rsp_valid && $past(op) != RDPA_OP_RD_PAYLOAD
		|-> rsp_len == 6'h00 && rsp_pipe == 3'h7 && rsp_payload == '0)
		else $error("payload fields set on a non payload answer");
	AST_FIFO_FLAGS: assert property (rsp_valid && $past(op) == RDPA_OP_RD_REG
		&& $past(addr) == 8'h17 |-> (rsp_byte & 8'hDC) == 8'h00 && !(&rsp_byte[1:0]))
		else $error("queue status flags inconsistent");

	cover property (rsp_valid && $past(op) == RDPA_OP_RD_PAYLOAD && rsp_len != 6'h00);
	cover property (rsp_valid && $past(op) == RDPA_OP_WR_ACK && rsp_byte[0]);
	cover property (rsp_valid && $past(addr) == 8'h17 && rsp_byte[1]);
endmodule

// *** rdpa_tb.sv ***
// Self-checking bench for both ends of the payload and acknowledge link
`timescale 1ns/1ps
`include "rdpa_defines.svh"
module rdpa_tb
	import rdpa_pkg::*;
;
	logic         clk_i, arst_n_i, wr, rd, irq, rx_valid, rx_ready, ack_take;
	logic         tx_req, tx_done, rx_active, ack_ok, ack_varlen, noack_en, ack_valid;
	logic         tx_en, rx_en, stby;
	logic [2:0]   rx_pipe, ack_pipe;
	logic [5:0]   rx_len, auto_ack, varlen, ack_len;
	logic [255:0] rx_data, ack_data;
	logic [7:0]   haddr, d0, d1;
	logic [31:0]  hwdata, rdata, rv;
	logic [264:0] rxq[$], ackq[$], e;
	int           fail_count, num_checks;
	logic [7:0]   ra[6] = '{8'h1C, 8'h1D, 8'h04, 8'h07, 8'h17, 8'h05};
	logic [7:0]   rr[6] = '{8'h00, 8'h00, 8'h00, 8'h0E, 8'h01, 8'h00};

	rdpa_if u_rdpa_if();
	rdpa_device #(.DEPTH(3), .LISTEN_CYC(10), .STEP_CYC(10)) u_rdpa_device
	(
		.clk_i(clk_i), .arst_n_i(arst_n_i), .link(u_rdpa_if), .rx_valid_i(rx_valid),
		.rx_pipe_i(rx_pipe), .rx_len_i(rx_len), .rx_data_i(rx_data), .rx_ready_o(rx_ready),
		.auto_ack_i(auto_ack), .varlen_active_o(varlen), .ack_varlen_o(ack_varlen),
		.no_ack_command_enable_o(noack_en), .ack_valid_o(ack_valid), .ack_pipe_o(ack_pipe),
		.ack_len_o(ack_len), .ack_data_o(ack_data), .ack_take_i(ack_take),
		.tx_request_i(tx_req), .tx_done_i(tx_done), .rx_active_i(rx_active),
		.ack_ok_i(ack_ok), .tx_enable_o(tx_en), .rx_enable_o(rx_en), .standby_o(stby)
	);
	rdpa_host u_rdpa_host
	(
		.clk_i(clk_i), .arst_n_i(arst_n_i), .link(u_rdpa_if), .addr_i(haddr),
		.wdata_i(hwdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq)
	);
	rdpa_chk u_rdpa_chk
	(
		.clk_i(clk_i), .arst_n_i(arst_n_i), .req(u_rdpa_if.req), .op(u_rdpa_if.op),
		.addr(u_rdpa_if.addr), .wdata(u_rdpa_if.wdata), .rsp_valid(u_rdpa_if.rsp_valid),
		.rsp_byte(u_rdpa_if.rsp_byte), .rsp_len(u_rdpa_if.rsp_len),
		.rsp_pipe(u_rdpa_if.rsp_pipe), .rsp_payload(u_rdpa_if.rsp_payload)
	);

	task automatic check(input logic [271:0] seen, input logic [271:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic hwr(input logic [7:0] a, input logic [31:0] d);
		haddr <= a;
		hwdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic hrd(input logic [7:0] a, output logic [31:0] d);
		haddr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		@(posedge clk_i);
		d = rdata;
	endtask

	// Issue one link command, poll busy with a bound, fetch the result
	task automatic cmd(input rdpa_op_type o, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] res, input logic [8:0] pl = 9'h000);
		int n;
		hwr(`RDPA_H_CMD, {d, a, 5'h00, pl[5:0], pl[8:6], o});
		n = 0;
		do
		begin
			hrd(`RDPA_H_CMD, res);
			n++;
		end
		while (res[0] !== 1'b0 && n < 20);
		if (res[0] !== 1'b0)
			fail_count++;
		hrd(`RDPA_H_RESULT, res);
	endtask

	task automatic rand_pkt(output logic [264:0] k);
		k[264:262] = 3'($urandom_range(5));
		k[261:256] = 6'($urandom_range(32, 1));
		for (int w = 0; w < 8; w++)
			k[32*w +: 32] = $urandom;
	endtask

	// Bytes beyond the packet length carry no meaning
	function automatic logic [264:0] cut(input logic [264:0] k);
		return {k[264:256], k[255:0] & (~256'h0 >> (256 - 8 * k[261:256]))};
	endfunction

	// One retransmit round: count listen, standby and total cycles up to the next send
	task automatic retx(input int act, output int lsn, output int sby, output int tot);
		logic seen;
		lsn = 0;
		sby = 0;
		tot = 0;
		tx_done <= 1'b1;
		rx_active <= (act > 0);
		@(posedge clk_i);
		tx_done <= 1'b0;
		do
		begin
			@(negedge clk_i);
			lsn += rx_en;
			sby += stby;
			tot++;
			seen = tx_en;
			@(posedge clk_i);
			if (tot == act) rx_active <= 1'b0;
		end
		while (seen !== 1'b1 && tot < 200);
	endtask

	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	initial
	begin
		#3000000;
		fail_count++;
		print_verdict();
	end

	initial
	begin : main_seq
		int t0, t3, ta, l0, l3, la, s0, s3, sa;
		{arst_n_i, wr, rd, rx_valid, ack_take, tx_req, tx_done, rx_active, ack_ok} = '0;
		{rx_pipe, rx_len, rx_data, auto_ack, haddr, hwdata} = '0;
		fail_count = 0;
		num_checks = 0;
		rv = $urandom(81);
		repeat (8) @(posedge clk_i);
		arst_n_i <= 1'b1;
		@(posedge clk_i);
		foreach (ra[i])
		begin
			cmd(RDPA_OP_RD_REG, ra[i], 8'h00, rv);
			check(rv[7:0], rr[i]);
		end
		hrd(8'h40, rv);
		check(rv, 32'h0);
		check(irq, 1'b0);
		$display("reset test done");
		for (int i = 0; i < 4; i++)
		begin
			d0 = 8'($urandom);
			d1 = 8'($urandom);
			d1[2] = i[0];
			auto_ack <= 6'($urandom);
			cmd(RDPA_OP_WR_REG, `RDPA_ADDR_VARLEN, d0, rv);
			cmd(RDPA_OP_WR_REG, `RDPA_ADDR_FEATURE, d1, rv);
			cmd(RDPA_OP_RD_REG, `RDPA_ADDR_VARLEN, 8'h00, rv);
			check(rv[7:0], d0 & 8'h3F);
			cmd(RDPA_OP_RD_REG, `RDPA_ADDR_FEATURE, 8'h00, rv);
			check(rv[7:0], d1 & 8'h07);
			check(varlen, d0[5:0] & auto_ack & {6{d1[2]}});
			check({ack_varlen, noack_en}, d1[1:0]);
		end
		$display("register test done");
		for (int i = 0; i < 4; i++)
		begin
			rand_pkt(e);
			{rx_pipe, rx_len, rx_data} <= e;
			rx_valid <= 1'b1;
			if (rxq.size() < 3)
				rxq.push_back(e);
			@(posedge clk_i);
		end
		rx_valid <= 1'b0;
		repeat (4) @(posedge clk_i);
		check(irq, 1'b0);
		hwr(`RDPA_H_IRQ_MASK, 32'h1);
		for (int n = 0; n < 8 && irq !== 1'b1; n++)
			@(posedge clk_i);
		check(irq, 1'b1);
		check(rx_ready, 1'b0);
		cmd(RDPA_OP_RD_REG, `RDPA_ADDR_FIFO_STATUS, 8'h00, rv);
		check(rv[7:0], 8'h02);
		while (rxq.size() > 0)
		begin
			cmd(RDPA_OP_RD_PAYLOAD, 8'h00, 8'h00, rv);
			e = rxq.pop_front();
			check(cut({rv[18:16], rv[13:8], u_rdpa_if.rsp_payload}), cut(e));
			cmd(RDPA_OP_WR_REG, `RDPA_ADDR_STATUS, 8'h40, rv);
			cmd(RDPA_OP_RD_REG, `RDPA_ADDR_STATUS, 8'h00, rv);
			check(rv[6], 1'b0);
			cmd(RDPA_OP_RD_REG, `RDPA_ADDR_FIFO_STATUS, 8'h00, rv);
			check(rv[7:0], {7'h00, rxq.size() == 0});
		end
		cmd(RDPA_OP_RD_PAYLOAD, 8'h00, 8'h00, rv);
		check({rv[18:16], rv[13:8]}, {3'h7, 6'h00});
		hrd(`RDPA_H_IRQ_STATUS, rv);
		check(rv, 32'h3);
		hwr(`RDPA_H_IRQ_STATUS, 32'h3);
		@(posedge clk_i);
		check(irq, 1'b0);
		$display("receive queue test done");
		for (int i = 0; i < 4; i++)
		begin
			rand_pkt(e);
			for (int w = 0; w < 8; w++)
				hwr(`RDPA_H_PAYLOAD + 8'(4 * w), e[32*w +: 32]);
			cmd(RDPA_OP_WR_ACK, 8'h00, 8'h00, rv, e[264:256]);
			check(rv[0], i == 3);
			if (i < 3)
				ackq.push_back(e);
		end
		cmd(RDPA_OP_RD_REG, `RDPA_ADDR_FIFO_STATUS, 8'h00, rv);
		check(rv[7:0], 8'h21);
		while (ackq.size() > 0)
		begin
			e = ackq.pop_front();
			check({ack_valid, cut({ack_pipe, ack_len, ack_data})}, {1'b1, cut(e)});
			ack_take <= 1'b1;
			@(posedge clk_i);
			ack_take <= 1'b0;
			repeat (2) @(posedge clk_i);
		end
		check(ack_valid, 1'b0);
		$display("acknowledge queue test done");
		cmd(RDPA_OP_WR_REG, `RDPA_ADDR_RTD, 8'h00, rv);
		hwr(`RDPA_H_CFG, 32'h2);
		hrd(`RDPA_H_CFG, rv);
		check(rv, {28'h0, d1[1] & ~d0[0], 1'b1, 2'h2});
		tx_req <= 1'b1;
		repeat (2) @(negedge clk_i);
		check(tx_en, 1'b1);
		@(posedge clk_i);
		tx_req <= 1'b0;
		retx(0, l0, s0, t0);
		cmd(RDPA_OP_WR_REG, `RDPA_ADDR_RTD, 8'h03, rv);
		hrd(`RDPA_H_CFG, rv);
		check(rv, {28'h0, d1[1] & ~d0[0], 1'b0, 2'h2});
		retx(0, l3, s3, t3);
		check(t3 - t0, 30);
		check({l0, l3}, {32'd10, 32'd10});
		retx(25, la, sa, ta);
		check(ta, t3);
		check({la >= 25, sa > 0}, 2'b11);
		tx_done <= 1'b1;
		@(posedge clk_i);
		tx_done <= 1'b0;
		ack_ok <= 1'b1;
		@(posedge clk_i);
		ack_ok <= 1'b0;
		@(negedge clk_i);
		check({tx_en, rx_en, stby}, 3'h0);
		$display("retransmit test done");
		print_verdict();
	end
endmodule
